// [pkg/pbsi_consts.vh]
// Constants for the basic status and identifier register block.
// Assumes inclusion by bare name from the design files.
`ifndef PBSI_CONSTS_VH
`define PBSI_CONSTS_VH

// Register addresses on the management bus
`define PBSI_REG_STATUS     5'h01
`define PBSI_REG_ID_HIGH    5'h02
`define PBSI_REG_ID_LOW     5'h03

// Fixed part of the status word: bits 14:11, 7, 6, 3 and 0 set
`define PBSI_STATUS_FIXED   16'h78c9

// Live and latched status bit positions
`define PBSI_BIT_AN_DONE    5
`define PBSI_BIT_RFAULT     4
`define PBSI_BIT_LINK       2
`define PBSI_BIT_JABBER     1

// Management frame fields
`define PBSI_PRE_LEN        6'h20
`define PBSI_OP_READ        2'h2
`define PBSI_OP_WRITE       2'h1
`define PBSI_OP_LAST        5'h01
`define PBSI_FIELD_LAST     5'h04
`define PBSI_DATA_LAST      5'h0f

`endif

// [design/pbsi_sync.v]
// Two-stage synchroniser for a group of asynchronous inputs.
// Assumes the inputs are independent levels; no bus coherence is implied.
module pbsi_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Data
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule // pbsi_sync

// [design/pbsi_status_id.v]
// Basic mode status and PHY identifier registers behind a serial management slave.
// Assumes mdc and mdio_in are asynchronous pins, event inputs come from mclk logic,
// and a pull-up keeps the shared data line high when nobody drives it.
// Writes are parsed to their end and dropped; nothing here is writable.
`include "pbsi_consts.vh"

module pbsi_status_id #(
    parameter [23:0] ORG_ID    = 24'h5a3c69,  // Arbitrary value
    parameter [5:0]  MODEL_NUM = 6'h2b,       // Arbitrary value
    parameter [3:0]  MODEL_REV = 4'h3         // Arbitrary value
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // Management pins
    input  wire       mdc,
    input  wire       mdio_in,
    output reg        mdio_out,
    output reg        mdio_oe,
    // Management address strap
    input  wire [4:0] phy_addr,
    // Status events from the transceiver
    input  wire       an_complete,
    input  wire       far_end_fault,
    input  wire       lp_remote_fault,
    input  wire       link_good,
    input  wire       jabber
);

    // Frame receiver states
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_OP    = 3'h2;
    localparam [2:0] ST_PHYAD = 3'h3;
    localparam [2:0] ST_REGAD = 3'h4;
    localparam [2:0] ST_TA    = 3'h5;
    localparam [2:0] ST_RDATA = 3'h6;
    localparam [2:0] ST_WDATA = 3'h7;

    // Read data for one register address
    function [15:0] reg_word;
        input [4:0]  addr;
        input        an;
        input        rf;
        input        lnk;
        input        jab;
        reg   [15:0] st;
        begin
            st = `PBSI_STATUS_FIXED;
            st[`PBSI_BIT_AN_DONE] = an;
            st[`PBSI_BIT_RFAULT]  = rf;
            st[`PBSI_BIT_LINK]    = lnk;
            st[`PBSI_BIT_JABBER]  = jab;
            case (addr)
                `PBSI_REG_STATUS:  reg_word = st;
                `PBSI_REG_ID_HIGH: reg_word = ORG_ID[21:6];
                `PBSI_REG_ID_LOW:  reg_word = {ORG_ID[5:0], MODEL_NUM, MODEL_REV};
                default:           reg_word = 16'h0000;
            endcase
        end
    endfunction

    // Only read and write opcodes start a transfer
    function op_ok;
        input [1:0] op;
        begin
            op_ok = (op == `PBSI_OP_READ) || (op == `PBSI_OP_WRITE);
        end
    endfunction

    // Answer word after one bit has gone out, msb first
    function [15:0] next_shift;
        input [15:0] w;
        begin
            next_shift = {w[14:0], 1'b0};
        end
    endfunction

    wire [6:0] sync_w;
    wire       mdc_s;
    wire       bit_s;
    wire [4:0] addr_s;

    // Clock pin, data pin and strap all pass two flip-flops before use
    pbsi_sync #(
        .W (7)
    ) u_sync (
        .clk   (mclk),
        .rst_n (rst_n),
        .d     ({mdc, mdio_in, phy_addr}),
        .q     (sync_w)
    );

    assign mdc_s  = sync_w[6];
    assign bit_s  = sync_w[5];
    assign addr_s = sync_w[4:0];

    // Frame receiver
    reg        mdc_prev_q;
    reg [2:0]  state_q;
    reg [4:0]  cnt_q;
    reg [5:0]  pre_cnt_q;
    reg        pre_ok_q;
    reg [1:0]  op_q;
    reg [4:0]  phyad_q;
    reg [4:0]  regad_q;
    reg [15:0] shift_q;
    // Status bits behind the status word
    reg        an_q;
    reg        rf_q;
    reg        link_q;
    reg        jab_q;

    wire rise     = mdc_s & ~mdc_prev_q;
    wire is_read  = (op_q == `PBSI_OP_READ);
    wire for_us   = (phyad_q == addr_s);
    // Status read is committed when the answer word is loaded
    wire rd_clr   = rise && (state_q == ST_TA) && (cnt_q == 5'h00) && is_read
                    && for_us && (regad_q == `PBSI_REG_STATUS);

    // Live negotiation-complete bit, one cycle behind its input
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            an_q <= 1'b0;
        end else begin
            an_q <= an_complete;
        end
    end

    // Remote fault latch; a new fault wins over the read clear
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rf_q <= 1'b0;
        end else begin
            rf_q <= far_end_fault | lp_remote_fault | (rf_q & ~rd_clr);
        end
    end

    // Latch-low link bit; rises again only on a status read with good link
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link_q <= 1'b0;
        end else begin
            link_q <= link_good & (link_q | rd_clr);
        end
    end

    // Jabber latch; a new jabber wins over the read clear
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            jab_q <= 1'b0;
        end else begin
            jab_q <= jabber | (jab_q & ~rd_clr);
        end
    end

    // Management frame receiver and read answer
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_prev_q <= 1'b0;
            state_q    <= ST_IDLE;
            cnt_q      <= 5'h00;
            pre_cnt_q  <= 6'h00;
            pre_ok_q   <= 1'b0;
            op_q       <= 2'h0;
            phyad_q    <= 5'h00;
            regad_q    <= 5'h00;
            shift_q    <= 16'h0000;
            mdio_out   <= 1'b0;
            mdio_oe    <= 1'b0;
        end else begin
            mdc_prev_q <= mdc_s;
            if (rise) begin
                case (state_q)
                    ST_IDLE: begin
                        if (bit_s) begin
                            if (pre_cnt_q != `PBSI_PRE_LEN) begin
                                pre_cnt_q <= pre_cnt_q + 6'h01;
                            end
                        end else begin
                            pre_cnt_q <= 6'h00;
                            // Preamble may be skipped once one full preamble was seen
                            if (pre_ok_q || (pre_cnt_q == `PBSI_PRE_LEN)) begin
                                pre_ok_q <= 1'b1;
                                state_q  <= ST_START;
                            end
                        end
                    end
                    ST_START: begin
                        cnt_q   <= 5'h00;
                        state_q <= bit_s ? ST_OP : ST_IDLE;
                    end
                    ST_OP: begin
                        op_q <= {op_q[0], bit_s};
                        if (cnt_q == `PBSI_OP_LAST) begin
                            cnt_q <= 5'h00;
                            if (op_ok({op_q[0], bit_s})) begin
                                state_q <= ST_PHYAD;
                            end else begin
                                pre_ok_q <= 1'b0;
                                state_q  <= ST_IDLE;
                            end
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    ST_PHYAD: begin
                        phyad_q <= {phyad_q[3:0], bit_s};
                        if (cnt_q == `PBSI_FIELD_LAST) begin
                            cnt_q   <= 5'h00;
                            state_q <= ST_REGAD;
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    ST_REGAD: begin
                        regad_q <= {regad_q[3:0], bit_s};
                        if (cnt_q == `PBSI_FIELD_LAST) begin
                            cnt_q   <= 5'h00;
                            state_q <= ST_TA;
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    ST_TA: begin
                        if (cnt_q == 5'h00) begin
                            // First turnaround bit: take the line, load the answer
                            cnt_q <= 5'h01;
                            if (is_read) begin
                                if (for_us) begin
                                    mdio_oe  <= 1'b1;
                                    mdio_out <= 1'b0;
                                    shift_q  <= reg_word(regad_q, an_q, rf_q, link_q, jab_q);
                                end
                            end else if (!bit_s) begin
                                pre_ok_q <= 1'b0;
                                state_q  <= ST_IDLE;
                            end
                        end else begin
                            cnt_q <= 5'h00;
                            // Second turnaround bit: the first data bit goes out
                            if (is_read) begin
                                if (for_us) begin
                                    mdio_out <= shift_q[15];
                                    shift_q  <= next_shift(shift_q);
                                end
                                state_q <= ST_RDATA;
                            end else if (bit_s) begin
                                pre_ok_q <= 1'b0;
                                state_q  <= ST_IDLE;
                            end else begin
                                state_q <= ST_WDATA;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (cnt_q == `PBSI_DATA_LAST) begin
                            // Last data bit is out: release the line
                            mdio_oe  <= 1'b0;
                            mdio_out <= 1'b0;
                            state_q  <= ST_IDLE;
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                            if (for_us) begin
                                mdio_out <= shift_q[15];
                                shift_q  <= next_shift(shift_q);
                            end
                        end
                    end
                    ST_WDATA: begin
                        // Write data is counted and dropped
                        if (cnt_q == `PBSI_DATA_LAST) begin
                            state_q <= ST_IDLE;
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // pbsi_status_id

// [sim/pbsi_host.sv]
// Management host model: drives mdc and its side of the data wire.
// Assumes the bench resolves the wire with a pull-up.
module pbsi_host (
    // Clock
    input  wire mclk,
    // Wire
    input  wire mdio,
    output reg  mdc,
    output reg  h_oe,
    output reg  h_d
);
    timeunit 1ns;
    timeprecision 1ps;
    reg need_q;
    initial {mdc, h_oe, h_d, need_q} = 4'b0011;
    // Twelve mclk per bit: drive after the fall, sample at the rise
    task bitx(input o, input d, output s);
        h_oe = o;
        h_d = d;
        repeat (6) @(negedge mclk);
        s = mdio;
        mdc = 1'b1;
        repeat (6) @(negedge mclk);
        mdc = 1'b0;
    endtask
    // Mode 0 sends preamble when due, 1 always, 2 never
    task frame(input [1:0] md, input [1:0] op, input [4:0] pa, input [4:0] ra,
               input [15:0] wd, output [15:0] rd);
        reg [31:0] f;
        reg        s;
        integer    i;
        f = {2'b01, op, pa, ra, 2'b10, wd};
        if (md == 2'd1 || (md == 2'd0 && need_q)) begin
            for (i = 0; i < 32; i = i + 1)
                bitx(1'b1, 1'b1, s);
            need_q = 1'b0;
        end
        for (i = 31; i >= 0; i = i - 1) begin
            bitx(op != 2'b10 || i > 17, f[i], s);
            rd = {rd[14:0], s};
        end
        h_oe = 1'b0;
        need_q = need_q | (op == 2'b00) | (op == 2'b11);
        @(negedge mclk);
    endtask
endmodule // pbsi_host

// [sim/pbsi_checker.sv]
// Checker for the status and identifier block, watching its pins only.
// Assumes bind to pbsi_status_id; read words are rebuilt from the data pin.
module pbsi_checker #(
    parameter [23:0] ORG_ID    = 24'h5a3c69,
    parameter [5:0]  MODEL_NUM = 6'h2b,
    parameter [3:0]  MODEL_REV = 4'h3
) (
    // Clock and reset
    input wire       mclk,
    input wire       rst_n,
    // Management pins
    input wire       mdc,
    input wire       mdio_in,
    input wire       mdio_out,
    input wire       mdio_oe,
    input wire [4:0] phy_addr,
    // Status events
    input wire       an_complete,
    input wire       far_end_fault,
    input wire       lp_remote_fault,
    input wire       link_good,
    input wire       jabber
);
    reg        mdc_q, oe_q, rf_q, jb_q, lk_q, rfc_q, jbc_q, lkc_q, anc_q;
    reg        fe_d, jb_d, lg_d, an_d, an_s;
    reg [5:0]  in_q;
    reg [15:0] wd_q;
    reg [4:0]  cnt_q, rg_q;
    wire       rise = mdc & ~mdc_q;
    wire       st   = mdio_oe & ~oe_q;
    wire       snap = st & (in_q[5:1] == 5'h01);
    wire       fin  = ~mdio_oe & oe_q;
    wire       rs   = fin & (rg_q == 5'h01);
    // Shadow of the latched bits: each status read clears fault and jabber and re-arms link
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {mdc_q, oe_q, rf_q, jb_q, lk_q, rfc_q, jbc_q, lkc_q, anc_q} <= 9'h000;
            {fe_d, jb_d, lg_d, an_d, an_s} <= 5'h00;
            {in_q, wd_q, cnt_q, rg_q} <= 32'h0;
        end else begin
            mdc_q <= mdc;
            oe_q <= mdio_oe;
            in_q <= rise ? {in_q[4:0], mdio_in} : in_q;
            wd_q <= (rise & mdio_oe) ? {wd_q[14:0], mdio_out} : wd_q;
            cnt_q <= st ? 5'h00 : cnt_q + {4'h0, rise & mdio_oe};
            rg_q <= st ? in_q[5:1] : rg_q;
            // Inputs taken a cycle late: the enable seen here trails the word snapshot
            {fe_d, jb_d, lg_d, an_d, an_s} <=
                {far_end_fault | lp_remote_fault, jabber, link_good, an_complete, an_d};
            rf_q <= (rf_q & ~snap) | fe_d;
            jb_q <= (jb_q & ~snap) | jb_d;
            lk_q <= lg_d & (lk_q | snap);
            if (snap) begin
                {rfc_q, jbc_q, lkc_q, anc_q} <= {rf_q, jb_q, lk_q, an_s};
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_fixed; rs |-> (wd_q & 16'hffc9) == 16'h78c9; endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed status bits wrong");
    property p_an; rs |-> wd_q[5] == anc_q; endproperty
    a_an: assert property (p_an) else $error("bad negotiation bit");
    property p_rf; rs |-> wd_q[4] == rfc_q; endproperty
    a_rf: assert property (p_rf) else $error("bad fault latch");
    property p_link; rs |-> wd_q[2] == lkc_q; endproperty
    a_link: assert property (p_link) else $error("bad link bit");
    property p_jab; rs |-> wd_q[1] == jbc_q; endproperty
    a_jab: assert property (p_jab) else $error("bad jabber latch");
    property p_idh; fin && rg_q == 5'h02 |-> wd_q == ORG_ID[21:6]; endproperty
    a_idh: assert property (p_idh) else $error("bad high identifier");
    property p_idl; fin && rg_q == 5'h03 |-> wd_q == {ORG_ID[5:0], MODEL_NUM, MODEL_REV}; endproperty
    a_idl: assert property (p_idl) else $error("bad low identifier");
    property p_len; $fell(mdio_oe) |-> cnt_q == 5'd17; endproperty
    a_len: assert property (p_len) else $error("bad drive length");
    c_stat: cover property (rs);
    c_flt: cover property (rs && wd_q[4]);
    c_idl: cover property (fin && rg_q == 5'h03);
endmodule // pbsi_checker
bind pbsi_status_id pbsi_checker #(
    .ORG_ID(ORG_ID), .MODEL_NUM(MODEL_NUM), .MODEL_REV(MODEL_REV)
) i_chk (
    .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr(phy_addr), .an_complete(an_complete),
    .far_end_fault(far_end_fault), .lp_remote_fault(lp_remote_fault),
    .link_good(link_good), .jabber(jabber)
);

// [sim/test_phy_basic_status_and_id_regs.sv]
// Self-checking bench: random status events and frames from the host model.
// Assumes the design, host model and checker are compiled before it.
module test_phy_basic_status_and_id_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [23:0] ORG = 24'h5a3c69;    // Arbitrary value
    localparam [9:0]  MR  = {6'h2b, 4'h3}; // Arbitrary model and revision
    localparam [4:0]  PA  = 5'h05;
    reg        mclk = 1'b0;
    reg        rst_n = 1'b0;
    reg        an = 1'b0, fef = 1'b0, lprf = 1'b0, lnk = 1'b0, jab = 1'b0;
    reg        rf_e, jab_e, lnk_e;
    reg [15:0] rd;
    integer    failures = 0, n_tests = 0, seed = 32'hf4776c02, k, n;
    wire       mdc, h_oe, h_d, mdio_out, mdio_oe;
    wire       mdio = mdio_oe ? mdio_out : (h_oe ? h_d : 1'b1);
    always #4 mclk = ~mclk;
    pbsi_status_id #(.ORG_ID(ORG), .MODEL_NUM(MR[9:4]), .MODEL_REV(MR[3:0])) i_dut (
        .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .phy_addr(PA), .an_complete(an), .far_end_fault(fef),
        .lp_remote_fault(lprf), .link_good(lnk), .jabber(jab));
    pbsi_host i_host (.mclk(mclk), .mdio(mdio), .mdc(mdc), .h_oe(h_oe), .h_d(h_d));
    function [15:0] exp_word(input [4:0] r);
        case (r)
            5'h01: exp_word = 16'h78c9 | {10'h0, an, rf_e, 1'b0, lnk_e, jab_e, 1'b0};
            5'h02: exp_word = ORG[21:6];
            5'h03: exp_word = {ORG[5:0], MR};
            default: exp_word = 16'h0000;
        endcase
    endfunction
    task check(input [15:0] g, input [15:0] e);
        n_tests = n_tests + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("FAIL at %0t: read %h, expected %h", $time, g, e);
        end
    endtask
    task rd_chk(input [1:0] md, input [4:0] r);
        reg [15:0] e;
        e = exp_word(r);
        i_host.frame(md, 2'b10, PA, r, 16'h0000, rd);
        check(rd, e);
        if (r == 5'h01)
            {rf_e, jab_e, lnk_e} = {2'b00, lnk};
    endtask
    task events;
        repeat (8) begin
            @(negedge mclk);
            k = $random(seed);
            {fef, lprf, jab} = {k[2:0] == 3'h0, k[5:3] == 3'h0, k[8:6] == 3'h0};
            {lnk, an} = {k[11:9] != 3'h0, k[12]};
            {rf_e, jab_e} = {rf_e | fef | lprf, jab_e | jab};
            lnk_e = lnk_e & lnk;
        end
        @(negedge mclk);
        {fef, lprf, jab} = 3'h0;
        repeat (4) @(negedge mclk);
    endtask
    task do_reset;
        rst_n = 1'b0;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        {rf_e, jab_e, lnk_e} = 3'h0;
        i_host.need_q = 1'b1;
        repeat (4) @(negedge mclk);
    endtask
    task end_sim;
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #500000;
        failures = failures + 1;
        end_sim;
    end
    initial begin
        do_reset;
        // No full preamble since reset: a bare frame gets no answer
        i_host.frame(2'd2, 2'b10, PA, 5'h01, 16'h0000, rd);
        check(rd, 16'hffff);
        rd_chk(2'd0, 5'h01);
        lnk = 1'b1;
        rd_chk(2'd2, 5'h01);
        for (n = 1; n < 8; n = n + 1)
            rd_chk(2'd2, n[4:0]);
        for (n = 0; n < 24; n = n + 1) begin
            events;
            k = $random(seed);
            if (n[2])
                i_host.frame(2'd0, 2'b01, PA, {3'h0, n[1:0]}, k[15:0] & 16'hf8ff, rd);
            rd_chk(2'd0, {3'h0, n[1:0]});
        end
        // A bad opcode forgets the preamble: a bare frame that follows is ignored
        for (n = 0; n < 2; n = n + 1) begin
            i_host.frame(2'd0, {n[0], n[0]}, PA, 5'h01, 16'h0000, rd);
            i_host.frame(2'd2, 2'b10, PA, 5'h01, 16'h0000, rd);
            check(rd, 16'hffff);
        end
        rd_chk(2'd0, 5'h01);
        {fef, jab} = 2'b11;
        @(negedge mclk);
        {fef, jab} = 2'b00;
        do_reset;
        rd_chk(2'd0, 5'h01);
        end_sim;
    end
endmodule // test_phy_basic_status_and_id_regs
